//--- hdl/dpbr_pkg.sv
// Constants shared by the peripheral/baseband ring DMA channel
package dpbr_pkg;
  // ------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [9:0] CTRL_IDX    = 10'h044;
  localparam logic [9:0] CH_STRIDE   = 10'h014;
  localparam logic [9:0] SRC_IDX     = 10'h045;
  localparam logic [9:0] DST_IDX     = 10'h046;
  localparam logic [9:0] SIZE_IDX    = 10'h047;
  localparam logic [9:0] CANCEL_IDX  = 10'h048;
  localparam logic [9:0] COUNT_IDX   = 10'h049;
  localparam logic [9:0] ERR_IDX     = 10'h030;
  localparam logic [9:0] BKUP_IDX    = 10'h10C;
  localparam logic [9:0] RXMASK_IDX  = 10'h10D;
  localparam logic [9:0] MODE_IDX    = 10'h100;
  localparam logic [9:0] RXBASE_IDX  = 10'h101;
  localparam logic [9:0] RXSIZE_IDX  = 10'h102;
  localparam logic [9:0] RXWPTR_IDX  = 10'h103;
  localparam logic [9:0] TXCFG_IDX   = 10'h110;
  localparam logic [9:0] TXBASE_IDX  = 10'h118;
  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int B_AUTO  = 31;
  localparam int B_WNUM  = 30;
  localparam int B_RNUM  = 28;
  localparam int SRCW_LO = 22;
  localparam int DSTW_LO = 20;
  localparam int SEL_LO  = 9;
  localparam int B_ABT   = 3;
  localparam int B_ERR   = 2;
  localparam int B_TC    = 1;
  localparam int B_EN    = 0;
  localparam logic [1:0]  WIDTH_WORD  = 2'h2;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] RX_RELOAD   = 32'h00FF_FFFF;
  localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
  localparam int          TX_CHANNELS = 6;
  // TX config fields: depth [1:0], wptr [3:2], rptr [5:4], slot [31:16]
  localparam int TXC_WP = 2;
  localparam int TXC_RP = 4;
  localparam int TXC_SZ = 16;
  // Depth code to pointer mask: one, two or four buffers
  function automatic logic [1:0] dep_mask(input logic [1:0] code);
    return (code == 2'h0) ? 2'h0 : (code == 2'h1) ? 2'h1 : 2'h3;
  endfunction : dep_mask
endpackage : dpbr_pkg

//--- hdl/dpbr_ring_addr.sv
// Ring buffer slot address: base plus masked pointer times slot size
module dpbr_ring_addr #(
  parameter int PW = 5
) (
  input  wire logic [31:0]   base,
  input  wire logic [PW-1:0] ptr,
  input  wire logic [PW-1:0] mask,
  input  wire logic [15:0]   slot,
  output logic      [31:0]   addr
);
  logic [31:0] idx;
  // Pointer wraps through the depth mask
  assign idx  = 32'(ptr & mask);
  assign addr = base + idx * 32'(slot);
endmodule : dpbr_ring_addr

//--- hdl/dpbr_channel.sv
// One DMA channel: peripheral to memory plus baseband TX/RX rings
module dpbr_channel #(
  parameter logic [9:0] CH_NUM = 10'h000
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] periph_req,
  output logic      [31:0] periph_ack,
  input  wire logic [31:0] periph_data,
  input  wire logic        periph_last,
  output logic             mem_wr_valid,
  input  wire logic        mem_wr_ready,
  input  wire logic        mem_wr_err,
  output logic      [31:0] mem_wr_addr,
  output logic      [31:0] mem_wr_data,
  input  wire logic        bb_tx_req,
  input  wire logic [2:0]  bb_tx_chn,
  input  wire logic        bb_tx_commit,
  input  wire logic        bb_tx_done,
  output logic             tx_fetch_valid,
  output logic      [31:0] tx_fetch_addr,
  output logic      [31:0] tx_fetch_words,
  input  wire logic        bb_rx_req,
  input  wire logic        bb_rx_commit,
  output logic             irq_tc,
  output logic             irq_error,
  output logic             irq_abort
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_WAIT = 2'b01, S_WR = 2'b11, S_CNT = 2'b10
  } dpbr_state_t;

  localparam logic [9:0] C_CTRL = dpbr_pkg::CTRL_IDX + CH_NUM * dpbr_pkg::CH_STRIDE;
  localparam logic [9:0] C_SRC  = dpbr_pkg::SRC_IDX + CH_NUM * dpbr_pkg::CH_STRIDE;
  localparam logic [9:0] C_DST  = dpbr_pkg::DST_IDX + CH_NUM * dpbr_pkg::CH_STRIDE;
  localparam logic [9:0] C_SIZE = dpbr_pkg::SIZE_IDX + CH_NUM * dpbr_pkg::CH_STRIDE;
  localparam logic [9:0] C_CNCL = dpbr_pkg::CANCEL_IDX + CH_NUM * dpbr_pkg::CH_STRIDE;
  localparam logic [9:0] C_CNT  = dpbr_pkg::COUNT_IDX + CH_NUM * dpbr_pkg::CH_STRIDE;

  dpbr_state_t state_q;
  logic [31:0] ctrl_q, src_q, dst_q, size_q, cnt_q, base_q, data_q;
  logic [31:0] req_m_q, req_s_q;
  logic [1:0]  err_q, mode_q;
  logic [7:0]  bkup_q, rxmask_q;
  logic [4:0]  rxwptr_q;
  logic [15:0] rxslot_q;
  logic [31:0] rxbase_q, rx_addr, rx_next, tx_addr, dflt_q;
  logic        ack_q, last_q;
  logic [1:0]  tx_dep_q [dpbr_pkg::TX_CHANNELS];
  logic [1:0]  tx_wp_q  [dpbr_pkg::TX_CHANNELS];
  logic [1:0]  tx_rp_q  [dpbr_pkg::TX_CHANNELS];
  logic [15:0] tx_slot_q[dpbr_pkg::TX_CHANNELS];
  logic [31:0] tx_base_q[dpbr_pkg::TX_CHANNELS];

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  logic       acc, wr, hit;
  logic [9:0] idx;
  assign idx    = paddr[11:2];
  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;

  // Read mux and address decode
  always_comb begin
    hit    = 1'b1;
    prdata = 32'h0000_0000;
    unique case (idx)
      C_CTRL:                 prdata = ctrl_q;
      C_SRC:                  prdata = src_q;
      C_DST:                  prdata = dst_q;
      C_SIZE:                 prdata = size_q;
      C_CNCL:                 prdata = 32'h0000_0000;
      C_CNT:                  prdata = cnt_q;
      dpbr_pkg::ERR_IDX:      prdata = {30'h0000_0000, err_q};
      dpbr_pkg::BKUP_IDX:     prdata = {24'h00_0000, bkup_q};
      dpbr_pkg::RXMASK_IDX:   prdata = {24'h00_0000, rxmask_q};
      dpbr_pkg::MODE_IDX:     prdata = {30'h0000_0000, mode_q};
      dpbr_pkg::RXBASE_IDX:   prdata = rxbase_q;
      dpbr_pkg::RXSIZE_IDX:   prdata = {16'h0000, rxslot_q};
      dpbr_pkg::RXWPTR_IDX:   prdata = {27'h000_0000, rxwptr_q};
      default: begin
        hit = 1'b0;
        for (int i = 0; i < dpbr_pkg::TX_CHANNELS; i++) begin
          if (idx == dpbr_pkg::TXCFG_IDX + 10'(i)) begin
            hit    = 1'b1;
            prdata = {tx_slot_q[i], 10'h000, tx_rp_q[i], tx_wp_q[i], tx_dep_q[i]};
          end
          if (idx == dpbr_pkg::TXBASE_IDX + 10'(i)) begin
            hit    = 1'b1;
            prdata = tx_base_q[i];
          end
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // Events
  // ------------------------------------------------------------
  logic busy, cancel, start, sw_stop, width_bad, wr_done;
  logic done, bus_err, fin, rx_multi, tx_multi;
  logic [4:0] sel;
  assign busy      = state_q != S_IDLE;
  assign sel       = ctrl_q[dpbr_pkg::SEL_LO +: 5];
  assign tx_multi  = mode_q[0];
  assign rx_multi  = mode_q[1];
  assign cancel    = wr & (idx == C_CNCL) & pwdata[0];
  assign sw_stop   = busy & ((wr & (idx == C_CTRL) & ~pwdata[dpbr_pkg::B_EN]) | cancel);
  assign width_bad = (ctrl_q[dpbr_pkg::SRCW_LO +: 2] != dpbr_pkg::WIDTH_WORD) |
                     (ctrl_q[dpbr_pkg::DSTW_LO +: 2] != dpbr_pkg::WIDTH_WORD);
  assign start     = (state_q == S_IDLE) & ctrl_q[dpbr_pkg::B_EN] & ~sw_stop;
  assign wr_done   = mem_wr_valid & mem_wr_ready;
  assign bus_err   = wr_done & mem_wr_err;
  assign done      = (wr_done & ~mem_wr_err & (state_q == S_CNT)) |
                     (wr_done & ~mem_wr_err & (state_q == S_WR) &
                      (last_q | size_q == 32'h0000_0001) & ~ctrl_q[dpbr_pkg::B_WNUM]);
  // Transfer finished, locally or by the baseband TX side
  assign fin       = done | bb_tx_done;

  // Peripheral request lines through two flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_m_q <= 32'h0000_0000;
      req_s_q <= 32'h0000_0000;
    end else begin
      req_m_q <= periph_req;
      req_s_q <= req_m_q;
    end
  end

  // ------------------------------------------------------------
  // Transfer state machine
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
    end else if (sw_stop | bus_err) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: if (start & ~width_bad) state_q <= S_WAIT;
        S_WAIT: if (req_s_q[sel] & ~ack_q) state_q <= S_WR;
        S_WR:   if (wr_done) begin
          if (last_q | size_q == 32'h0000_0001)
            state_q <= ctrl_q[dpbr_pkg::B_WNUM] ? S_CNT : S_IDLE;
          else
            state_q <= S_WAIT;
        end
        S_CNT:  if (wr_done) state_q <= S_IDLE;
      endcase
    end
  end

  // Four-phase ack: held until the selected request drops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_q  <= 1'b0;
      data_q <= 32'h0000_0000;
      last_q <= 1'b0;
    end else if (state_q == S_WAIT && req_s_q[sel] && !ack_q) begin
      ack_q  <= 1'b1;
      data_q <= periph_data;
      last_q <= periph_last;
    end else if (!req_s_q[sel]) begin
      ack_q  <= 1'b0;
    end
  end
  assign periph_ack = 32'(ack_q) << sel;

  // Memory write port: data word or received count before base
  assign mem_wr_valid = (state_q == S_WR) | (state_q == S_CNT);
  assign mem_wr_addr  = (state_q == S_CNT) ? base_q - dpbr_pkg::WORD_BYTES : dst_q;
  assign mem_wr_data  = (state_q == S_CNT) ? cnt_q : data_q;

  // ------------------------------------------------------------
  // Control register, enable and auto-load
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= dpbr_pkg::CTRL_RST;
    end else begin
      if (fin | bus_err | (start & width_bad) | cancel)
        ctrl_q[dpbr_pkg::B_EN] <= 1'b0;
      if (fin)
        ctrl_q[dpbr_pkg::B_RNUM] <= bkup_q[0];
      if ((bb_tx_req | bb_rx_req) & ctrl_q[dpbr_pkg::B_RNUM])
        ctrl_q[dpbr_pkg::B_RNUM] <= 1'b0;
      if ((bb_tx_req | bb_rx_req) & ctrl_q[dpbr_pkg::B_AUTO])
        ctrl_q[dpbr_pkg::B_EN] <= 1'b1;
      if (wr & idx == C_CTRL)
        ctrl_q <= pwdata;
    end
  end

  // Addresses, size and received count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      src_q  <= 32'h0000_0000;
      dflt_q <= 32'h0000_0000;
      dst_q  <= 32'h0000_0000;
      size_q <= 32'h0000_0000;
      cnt_q  <= 32'h0000_0000;
      base_q <= 32'h0000_0000;
    end else begin
      if (start) begin
        base_q <= dst_q;
        cnt_q  <= 32'h0000_0000;
      end
      if (wr_done & state_q == S_WR) begin
        dst_q  <= dst_q + dpbr_pkg::WORD_BYTES;
        size_q <= size_q - 32'h0000_0001;
        cnt_q  <= cnt_q + 32'h0000_0001;
      end
      if (bb_tx_req & tx_multi)
        src_q <= tx_addr;
      if (bb_tx_req & ctrl_q[dpbr_pkg::B_RNUM])
        size_q <= {16'h0000, tx_slot_q[bb_tx_chn]} >> 2;
      if (bb_rx_req & ctrl_q[dpbr_pkg::B_RNUM])
        size_q <= {16'h0000, rxslot_q} >> 2;
      if (fin & rx_multi) begin
        dst_q  <= rx_addr;
        size_q <= dpbr_pkg::RX_RELOAD;
      end
      if (bb_rx_commit & rx_multi)
        dst_q <= rx_next;
      if (wr & idx == C_SRC)  src_q  <= pwdata;
      // Software copy survives the hardware reloads of src_q
      if (wr & idx == C_SRC)  dflt_q <= pwdata;
      if (wr & idx == C_DST)  dst_q  <= pwdata;
      if (wr & idx == C_SIZE) size_q <= pwdata;
    end
  end

  // TX fetch request toward the memory reader
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_fetch_valid <= 1'b0;
      tx_fetch_addr  <= 32'h0000_0000;
      tx_fetch_words <= 32'h0000_0000;
    end else begin
      tx_fetch_valid <= bb_tx_req;
      tx_fetch_addr  <= tx_multi ? tx_addr : src_q;
      tx_fetch_words <= ctrl_q[dpbr_pkg::B_RNUM] ?
                        {16'h0000, tx_slot_q[bb_tx_chn]} >> 2 : size_q;
    end
  end

  // Interrupt pulses and sticky error causes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_tc    <= 1'b0;
      irq_error <= 1'b0;
      irq_abort <= 1'b0;
      err_q     <= 2'h0;
    end else begin
      irq_tc    <= fin & ctrl_q[dpbr_pkg::B_TC];
      irq_error <= (bus_err | (start & width_bad)) & ctrl_q[dpbr_pkg::B_ERR];
      irq_abort <= cancel & ctrl_q[dpbr_pkg::B_ABT];
      if (wr & idx == dpbr_pkg::ERR_IDX)
        err_q <= err_q & ~pwdata[1:0];
      if (start & width_bad) err_q[0] <= 1'b1;
      if (bus_err)           err_q[1] <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Baseband ring state
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bkup_q   <= 8'h00;
      rxmask_q <= 8'h00;
      mode_q   <= 2'h0;
      rxbase_q <= 32'h0000_0000;
      rxslot_q <= 16'h0000;
      rxwptr_q <= 5'h00;
    end else begin
      if (bb_rx_commit & rx_multi)
        rxwptr_q <= (rxwptr_q + 5'h01) & rxmask_q[4:0];
      if (wr & idx == dpbr_pkg::BKUP_IDX)   bkup_q   <= pwdata[7:0];
      if (wr & idx == dpbr_pkg::RXMASK_IDX) rxmask_q <= pwdata[7:0];
      if (wr & idx == dpbr_pkg::MODE_IDX)   mode_q   <= pwdata[1:0];
      if (wr & idx == dpbr_pkg::RXBASE_IDX) rxbase_q <= pwdata;
      if (wr & idx == dpbr_pkg::RXSIZE_IDX) rxslot_q <= pwdata[15:0];
      if (wr & idx == dpbr_pkg::RXWPTR_IDX) rxwptr_q <= pwdata[4:0];
    end
  end

  // Per-channel TX rings: software write pointer, hardware read pointer
  for (genvar g = 0; g < dpbr_pkg::TX_CHANNELS; g++) begin : g_tx
    logic hit_cfg, bump;
    assign hit_cfg = wr & (idx == dpbr_pkg::TXCFG_IDX + 10'(g));
    assign bump = bb_tx_commit & tx_multi & (bb_tx_chn == 3'(g)) &
                  (tx_rp_q[g] != tx_wp_q[g]);
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        tx_dep_q[g]  <= 2'h0;
        tx_wp_q[g]   <= 2'h0;
        tx_rp_q[g]   <= 2'h0;
        tx_slot_q[g] <= 16'h0000;
        tx_base_q[g] <= 32'h0000_0000;
      end else begin
        if (bump)
          tx_rp_q[g] <= (tx_rp_q[g] + 2'h1) & dpbr_pkg::dep_mask(tx_dep_q[g]);
        if (hit_cfg) begin
          tx_dep_q[g]  <= pwdata[1:0];
          tx_wp_q[g]   <= pwdata[dpbr_pkg::TXC_WP +: 2];
          tx_slot_q[g] <= pwdata[dpbr_pkg::TXC_SZ +: 16];
        end
        if (wr & idx == dpbr_pkg::TXBASE_IDX + 10'(g)) tx_base_q[g] <= pwdata;
      end
    end
  end

  // Send slot: default buffer when ring empty, else read pointer slot
  logic [2:0]  tch;
  logic        tx_empty;
  logic [31:0] tx_slot_addr;
  assign tch      = (bb_tx_chn < 3'(dpbr_pkg::TX_CHANNELS)) ? bb_tx_chn : 3'h0;
  assign tx_empty = tx_rp_q[tch] == tx_wp_q[tch];
  assign tx_addr  = tx_empty ? dflt_q : tx_slot_addr;

  dpbr_ring_addr #(.PW(2)) u_tx_ring (
    .base (tx_base_q[tch]),
    .ptr  (tx_rp_q[tch]),
    .mask (dpbr_pkg::dep_mask(tx_dep_q[tch])),
    .slot (tx_slot_q[tch]),
    .addr (tx_slot_addr)
  );
  dpbr_ring_addr #(.PW(5)) u_rx_ring (
    .base (rxbase_q),
    .ptr  (rxwptr_q),
    .mask (rxmask_q[4:0]),
    .slot (rxslot_q),
    .addr (rx_addr)
  );
  dpbr_ring_addr #(.PW(5)) u_rx_next (
    .base (rxbase_q),
    .ptr  (rxwptr_q + 5'h01),
    .mask (rxmask_q[4:0]),
    .slot (rxslot_q),
    .addr (rx_next)
  );

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_count_phase;
    (state_q == S_CNT) ##0 (mem_wr_addr == base_q - dpbr_pkg::WORD_BYTES);
  endsequence
  property p_count_word;
    @(posedge mclk) disable iff (rst)
      (state_q == S_WR && wr_done && !mem_wr_err && last_q && ctrl_q[dpbr_pkg::B_WNUM])
      |=> s_count_phase;
  endproperty
  a_count_word: assert property (p_count_word) else $error("count word missing");
  property p_ack_sel;
    @(posedge mclk) disable iff (rst) $rose(ack_q) |-> $past(req_s_q[sel]);
  endproperty
  a_ack_sel: assert property (p_ack_sel) else $error("ack without request");
  property p_abort_irq;
    @(posedge mclk) disable iff (rst) (cancel && ctrl_q[dpbr_pkg::B_ABT]) |=> irq_abort;
  endproperty
  a_abort_irq: assert property (p_abort_irq) else $error("abort irq missing");
  property p_err_irq;
    @(posedge mclk) disable iff (rst)
      (bus_err && ctrl_q[dpbr_pkg::B_ERR]) |=> irq_error && state_q == S_IDLE;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error irq missing");
  property p_tc_irq;
    @(posedge mclk) disable iff (rst) irq_tc |-> $past(fin) && $past(ctrl_q[dpbr_pkg::B_TC]);
  endproperty
  a_tc_irq: assert property (p_tc_irq) else $error("stray tc irq");
  property p_auto_en;
    @(posedge mclk) disable iff (rst)
      (bb_rx_req && ctrl_q[dpbr_pkg::B_AUTO] && !(wr && idx == C_CTRL)) |=> ctrl_q[dpbr_pkg::B_EN];
  endproperty
  a_auto_en: assert property (p_auto_en) else $error("auto enable missed");
  property p_rx_reload;
    @(posedge mclk) disable iff (rst)
      (done && rx_multi && !(wr && idx == C_SIZE)) |=> size_q == dpbr_pkg::RX_RELOAD;
  endproperty
  a_rx_reload: assert property (p_rx_reload) else $error("rx size not reloaded");
  property p_stop;
    @(posedge mclk) disable iff (rst) sw_stop |=> state_q == S_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("abort did not stop");
endmodule : dpbr_channel

//--- testbench/dpbr_far_model.sv
// Far side model: one request/ack peripheral and a memory write port
module dpbr_far_model #(
  parameter int SEL = 3
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  output logic      [31:0] periph_req,
  input  wire logic [31:0] periph_ack,
  output logic      [31:0] periph_data,
  output logic             periph_last,
  input  wire logic        mem_wr_valid,
  output logic             mem_wr_ready,
  output logic             mem_wr_err,
  input  wire logic [31:0] mem_wr_addr,
  input  wire logic [31:0] mem_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] log_a[$];
  logic [31:0] log_d[$];
  int          stall = 0;
  int          wait_n;
  initial periph_req = 32'h0000_0000;
  initial periph_data = 32'h0000_0000;
  initial periph_last = 1'b0;
  logic        err_on = 1'b0;
  // Error answer rides with ready while the bench asks for it
  assign mem_wr_err = err_on & mem_wr_ready;
  // Memory takes a write after a programmable stall and logs it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_wr_ready <= 1'b0;
      wait_n <= 0;
    end else begin
      mem_wr_ready <= mem_wr_valid && !mem_wr_ready && wait_n >= stall;
      wait_n <= (mem_wr_valid && !mem_wr_ready) ? wait_n + 1 : 0;
      if (mem_wr_valid && mem_wr_ready) begin
        log_a.push_back(mem_wr_addr);
        log_d.push_back(mem_wr_data);
      end
    end
  end
  // One word per four-phase handshake; released lines show inverted data
  task send(input logic [31:0] w, input logic l);
    @(posedge mclk);
    periph_req[SEL] <= 1'b1;
    periph_data <= w;
    periph_last <= l;
    do @(posedge mclk); while (periph_ack[SEL] !== 1'b1);
    periph_req[SEL] <= 1'b0;
    periph_data <= ~w;
    periph_last <= ~l;
    do @(posedge mclk); while (periph_ack[SEL] !== 1'b0);
  endtask : send
endmodule : dpbr_far_model

//--- testbench/dma_periph_baseband_rings_test.sv
// Self-checking bench for the peripheral and baseband ring DMA channel
module dma_periph_baseband_rings_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        bb_tx_req = 1'b0, bb_tx_commit = 1'b0, bb_tx_done = 1'b0;
  logic        bb_rx_req = 1'b0, bb_rx_commit = 1'b0;
  logic [2:0]  bb_tx_chn = 3'h2;
  logic [31:0] prdata, periph_req, periph_ack, periph_data, mem_wr_addr, mem_wr_data;
  logic [31:0] tx_fetch_addr, tx_fetch_words, rd;
  logic        pready, pslverr, periph_last, mem_wr_valid, mem_wr_ready, mem_wr_err;
  logic        tx_fetch_valid, irq_tc, irq_error, irq_abort, serr;
  int          n_fail = 0, tests_run = 0, n_tc = 0, n_err = 0, n_abt = 0;

  dpbr_channel u_dpbr_channel (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .periph_req, .periph_ack, .periph_data, .periph_last,
    .mem_wr_valid, .mem_wr_ready, .mem_wr_err, .mem_wr_addr, .mem_wr_data, .bb_tx_req,
    .bb_tx_chn, .bb_tx_commit, .bb_tx_done, .tx_fetch_valid, .tx_fetch_addr,
    .tx_fetch_words, .bb_rx_req, .bb_rx_commit, .irq_tc, .irq_error, .irq_abort);
  dpbr_far_model u_dpbr_far_model (.mclk, .rst, .periph_req, .periph_ack, .periph_data,
    .periph_last, .mem_wr_valid, .mem_wr_ready, .mem_wr_err, .mem_wr_addr, .mem_wr_data);

  // Clock and interrupt pulse counters
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) begin
    if (irq_tc === 1'b1) n_tc <= n_tc + 1;
    if (irq_error === 1'b1) n_err <= n_err + 1;
    if (irq_abort === 1'b1) n_abt <= n_abt + 1;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // APB setup then access until pready
  task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rchk(input logic [9:0] idx, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd & m, exp);
  endtask : rchk
  // One-cycle baseband pulses: rx commit, rx req, tx done, tx commit, tx req
  task pulse(input logic [4:0] m);
    @(posedge mclk);
    {bb_rx_commit, bb_rx_req, bb_tx_done, bb_tx_commit, bb_tx_req} <= m;
    @(posedge mclk);
    {bb_rx_commit, bb_rx_req, bb_tx_done, bb_tx_commit, bb_tx_req} <= 5'h00;
  endtask : pulse

  task t_regs;
    rchk(dpbr_pkg::CTRL_IDX, 32'hFFFF_FFFF, dpbr_pkg::CTRL_RST);
    apb(1'b0, 10'h3FF, 32'h0000_0000);
    chk({31'h0000_0000, serr}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(1'b1, dpbr_pkg::RXMASK_IDX, 32'h0000_0003);
    rchk(dpbr_pkg::RXMASK_IDX, 32'h0000_001F, 32'h0000_0003);
  endtask : t_regs
  // Two words, slow memory, count word before destination
  task t_periph;
    apb(1'b1, dpbr_pkg::DST_IDX, 32'h0000_1000);
    apb(1'b1, dpbr_pkg::SIZE_IDX, 32'hFFFF_FFFF);
    // Count write, word widths, request line 3, tc irq, enable
    apb(1'b1, dpbr_pkg::CTRL_IDX, 32'h42A0_0603);
    u_dpbr_far_model.stall = 2;
    u_dpbr_far_model.send(32'hA5A5_0001, 1'b0);
    u_dpbr_far_model.send(32'h5A5A_0002, 1'b1);
    for (int i = 0; i < 60 && n_tc == 0; i++) @(posedge mclk);
    chk(n_tc, 1);
    chk(u_dpbr_far_model.log_a.size(), 3);
    chk(u_dpbr_far_model.log_a[1], 32'h0000_1004);
    chk(u_dpbr_far_model.log_d[1], 32'h5A5A_0002);
    chk(u_dpbr_far_model.log_a[2], 32'h0000_0FFC);
    chk(u_dpbr_far_model.log_d[2], 32'h0000_0002);
    rchk(dpbr_pkg::CTRL_IDX, 32'h0000_0001, 32'h0000_0000);
  endtask : t_periph
  task t_err_abort;
    apb(1'b1, dpbr_pkg::CTRL_IDX, 32'h0000_0005);
    for (int i = 0; i < 20 && n_err == 0; i++) @(posedge mclk);
    chk(n_err, 1);
    rchk(dpbr_pkg::ERR_IDX, 32'h0000_0001, 32'h0000_0001);
    apb(1'b1, dpbr_pkg::CTRL_IDX, 32'h00A0_0609);
    apb(1'b1, dpbr_pkg::CANCEL_IDX, 32'h0000_0001);
    for (int i = 0; i < 20 && n_abt == 0; i++) @(posedge mclk);
    chk(n_abt, 1);
  endtask : t_err_abort
  task tx_fetch(input logic [31:0] exp);
    pulse(5'h01);
    for (int i = 0; i < 4 && tx_fetch_valid !== 1'b1; i++) @(posedge mclk);
    chk({31'h0000_0000, tx_fetch_valid}, 32'h0000_0001);
    chk(tx_fetch_addr, exp);
    chk(tx_fetch_words, 32'h0000_0010);
  endtask : tx_fetch
  // Two-buffer ring on channel 2, slot 64 bytes, read pointer wraps
  task t_rings;
    apb(1'b1, dpbr_pkg::MODE_IDX, 32'h0000_0003);
    apb(1'b1, dpbr_pkg::SRC_IDX, 32'h0000_5000);
    apb(1'b1, dpbr_pkg::BKUP_IDX, 32'h0000_0001);
    apb(1'b1, dpbr_pkg::CTRL_IDX, 32'h1000_0000);
    apb(1'b1, dpbr_pkg::TXBASE_IDX + 10'h002, 32'h0000_2000);
    apb(1'b1, dpbr_pkg::TXCFG_IDX + 10'h002, 32'h0040_0005);
    tx_fetch(32'h0000_2000);
    rchk(dpbr_pkg::CTRL_IDX, 32'h1000_0000, 32'h0000_0000);
    pulse(5'h02);
    rchk(dpbr_pkg::TXCFG_IDX + 10'h002, 32'h0000_0030, 32'h0000_0010);
    pulse(5'h04);
    rchk(dpbr_pkg::CTRL_IDX, 32'h1000_0000, 32'h1000_0000);
    apb(1'b1, dpbr_pkg::TXCFG_IDX + 10'h002, 32'h0040_0001);
    tx_fetch(32'h0000_2040);
    pulse(5'h02);
    tx_fetch(32'h0000_5000);
    apb(1'b1, dpbr_pkg::RXBASE_IDX, 32'h0000_3000);
    apb(1'b1, dpbr_pkg::RXSIZE_IDX, 32'h0000_0020);
    pulse(5'h10);
    rchk(dpbr_pkg::RXWPTR_IDX, 32'h0000_001F, 32'h0000_0001);
  endtask : t_rings
  // Baseband request enables the channel; completion reloads the RX slot
  task t_rx_auto;
    apb(1'b1, dpbr_pkg::CTRL_IDX, 32'h80A0_0602);
    pulse(5'h08);
    rchk(dpbr_pkg::CTRL_IDX, 32'h0000_0001, 32'h0000_0001);
    u_dpbr_far_model.send(32'hC3C3_0003, 1'b1);
    for (int i = 0; i < 60 && n_tc < 2; i++) @(posedge mclk);
    chk(n_tc, 2);
    chk(u_dpbr_far_model.log_a[3], 32'h0000_3020);
    chk(u_dpbr_far_model.log_d[3], 32'hC3C3_0003);
    rchk(dpbr_pkg::SIZE_IDX, 32'hFFFF_FFFF, 32'h00FF_FFFF);
    rchk(dpbr_pkg::DST_IDX, 32'hFFFF_FFFF, 32'h0000_3020);
  endtask : t_rx_auto
  // Memory error answer ends the transfer and raises the error pulse
  task t_bus_err;
    u_dpbr_far_model.err_on <= 1'b1;
    apb(1'b1, dpbr_pkg::CTRL_IDX, 32'h00A0_0605);
    u_dpbr_far_model.send(32'h0F0F_0004, 1'b1);
    for (int i = 0; i < 60 && n_err < 2; i++) @(posedge mclk);
    u_dpbr_far_model.err_on <= 1'b0;
    chk(n_err, 2);
    rchk(dpbr_pkg::ERR_IDX, 32'h0000_0002, 32'h0000_0002);
    rchk(dpbr_pkg::CTRL_IDX, 32'h0000_0001, 32'h0000_0000);
  endtask : t_bus_err

  task give_verdict;
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_periph();
    t_err_abort();
    t_rings();
    t_rx_auto();
    t_bus_err();
    give_verdict();
  end
endmodule : dma_periph_baseband_rings_test
